// file: hdl/usb_ctrl_pkg.sv
// Shared constants and types for the USB control and event register block
package usb_ctrl_pkg;

  // ==========================================================
  // Bus and sizing
  localparam int ADDR_W = 10;
  localparam int NUM_EP = 8;
  localparam int SEL_W = 3;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_EP_SEL = 8'hca;
  localparam logic [7:0] IDX_EP_CS = 8'hcb;
  localparam logic [7:0] IDX_CTRL = 8'he0;
  localparam logic [7:0] IDX_PFLAGS = 8'he1;
  localparam logic [7:0] IDX_PMASK = 8'he2;
  localparam logic [7:0] IDX_EP_SUM = 8'he3;
  localparam logic [7:0] IDX_EP_MASK = 8'he4;
  localparam logic [7:0] IDX_GSTATE = 8'he6;

  // ==========================================================
  // Field positions
  localparam int CR_WAKE_BIT = 7;
  localparam int CR_PULLUP_BIT = 5;
  localparam int CR_ENABLE_BIT = 1;
  localparam int PF_BUS_RESET = 4;
  localparam int PF_SOF = 3;
  localparam int PF_WAKE = 2;
  localparam int PF_RESUME = 1;
  localparam int PF_SUSPEND = 0;
  localparam int CS_ISO_ERR = 6;
  localparam int CS_STALL = 3;
  localparam int CS_SETUP = 2;
  localparam int CS_DATA_RECEIVED = 1;
  localparam int CS_TXC = 0;
  localparam int GS_RSM_ACTIVE = 3;
  localparam int GS_RWU_ALLOW = 2;

  // ==========================================================
  // Writable-bit masks and reset values
  localparam logic [7:0] CR_WMASK = 8'ha2;
  localparam logic [7:0] PF_WMASK = 8'h1f;
  localparam logic [7:0] PM_WMASK = 8'h0f;
  localparam logic [7:0] SEL_WMASK = 8'h07;
  localparam logic [3:0] CS_STAT_MASK = 4'hf;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PMASK = 8'h02;

  // ==========================================================
  // Timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam int WAKE_TIME_US = 13000;
  localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_FREQ_MHZ;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    EP_CONTROL = 2'b00,
    EP_ISO = 2'b01,
    EP_BULK = 2'b10,
    EP_INTR = 2'b11
  } ep_type_t;

  typedef enum logic [1:0] {
    WK_IDLE = 2'b00,
    WK_SIGNAL = 2'b01,
    WK_WAIT_CLR = 2'b11
  } wake_state_t;

endpackage

// file: hdl/usb_device_ctrl_irq_regs.sv
// USB device control, protocol event and endpoint event registers over APB
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module usb_device_ctrl_irq_regs
  import usb_ctrl_pkg::*;
  #(
    parameter int WAKE_CNT = WAKE_CYCLES
  )
  (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_reduce_usb,
    input wire logic bus_suspended,
    input wire logic bus_reset_end_evt,
    input wire logic frame_start_evt,
    input wire logic resume_evt,
    input wire logic suspend_evt,
    input wire logic [NUM_EP-1:0] txc_evt,
    input wire logic [NUM_EP-1:0] data_received_evt,
    input wire logic [NUM_EP-1:0] setup_evt,
    input wire logic [NUM_EP-1:0] stall_evt,
    input wire logic [NUM_EP-1:0] iso_crc_bad,
    input wire logic [NUM_EP-1:0] iso_crc_good,
    input wire logic [2*NUM_EP-1:0] endpoint_type,
    input wire logic [NUM_EP-1:0] endpoint_dir_in,
    output logic attach_pullup_on,
    output logic usb_run,
    output logic ctrl_reset,
    output logic resume_k_drive,
    output logic [SEL_W-1:0] endpoint_select,
    output logic protocol_irq,
    output logic endpoint_irq
  );

  // ==========================================================
  // Declarations
  logic [7:0] ctrl_q;
  logic armed_q;
  logic run_q;
  logic ctrl_reset_q;
  logic [7:0] pflags_q;
  logic [7:0] pmask_q;
  logic [7:0] epmask_q;
  logic [SEL_W-1:0] sel_q;
  logic rwu_allow_q;
  logic resume_on_q;
  logic [3:0] ep_stat_q [NUM_EP];
  logic [NUM_EP-1:0] iso_err_q;
  logic [NUM_EP-1:0] summary_q;
  logic [NUM_EP-1:0] ep_cond;
  wake_state_t wake_state_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic pirq_q;
  logic eirq_q;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic [7:0] rdata_d;
  logic hit;
  logic wr_en;
  logic wr_ctrl;
  logic wr_pflags;
  logic wr_pmask;
  logic wr_epmask;
  logic wr_sel;
  logic wr_cs;
  logic wr_gs;
  logic wake_start;
  logic timer_done;
  logic [7:0] pflags_set;

  // ==========================================================
  // Address decode: index is byte address divided by four
  assign idx = paddr[9:2];
  assign wdat = pwdata[7:0];
  always_comb
  begin
    hit = 1'b0;
    case (idx)
      IDX_EP_SEL, IDX_EP_CS, IDX_CTRL, IDX_PFLAGS, IDX_PMASK,
      IDX_EP_SUM, IDX_EP_MASK, IDX_GSTATE: hit = (paddr[1:0] == 2'b00);
      default: hit = 1'b0;
    endcase
  end

  // Write strobes take effect at the access edge with pready high
  assign wr_en = psel && penable && pready_q && pwrite && pstrb[0] && hit;
  assign wr_ctrl = wr_en && (idx == IDX_CTRL);
  assign wr_pflags = wr_en && (idx == IDX_PFLAGS);
  assign wr_pmask = wr_en && (idx == IDX_PMASK);
  assign wr_epmask = wr_en && (idx == IDX_EP_MASK);
  assign wr_sel = wr_en && (idx == IDX_EP_SEL);
  assign wr_cs = wr_en && (idx == IDX_EP_CS);
  assign wr_gs = wr_en && (idx == IDX_GSTATE);

  // ==========================================================
  // Read multiplexer; unlisted bits read zero
  always_comb
  begin
    rdata_d = RST_ZERO;
    case (idx)
      IDX_EP_SEL: rdata_d = {5'h00, sel_q};
      IDX_EP_CS: rdata_d = {1'b0, iso_err_q[sel_q], 2'b00,
                            ep_stat_q[sel_q]};
      IDX_CTRL: rdata_d = ctrl_q & CR_WMASK;
      IDX_PFLAGS: rdata_d = pflags_q & PF_WMASK;
      IDX_PMASK: rdata_d = pmask_q & PM_WMASK;
      IDX_EP_SUM: rdata_d = summary_q;
      IDX_EP_MASK: rdata_d = epmask_q;
      IDX_GSTATE: rdata_d = {4'h0, resume_on_q, rwu_allow_q, 2'b00};
      default: rdata_d = RST_ZERO;
    endcase
  end

  // ==========================================================
  // APB answer: one wait-free access cycle, error on unmapped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= psel && !penable;
      if (psel && !penable)
      begin
        pslverr_q <= !hit;
        prdata_q <= (hit && !pwrite) ? {24'h00_0000, rdata_d} : 32'h0;
      end
    end
  end

  // ==========================================================
  // Control register, enable arming and run qualification
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= RST_ZERO;
      armed_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      ctrl_q <= wdat & CR_WMASK;
      if (!wdat[CR_ENABLE_BIT])
      begin
        armed_q <= 1'b1;
      end
    end
  end

  // Run only when enabled, armed and not power-reduced
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= 1'b0;
      ctrl_reset_q <= 1'b1;
    end
    else
    begin
      run_q <= ctrl_q[CR_ENABLE_BIT] && armed_q
               && !power_reduce_usb;
      ctrl_reset_q <= !(ctrl_q[CR_ENABLE_BIT] && armed_q);
    end
  end

  // ==========================================================
  // Global state: remote wake-up allow bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rwu_allow_q <= 1'b0;
    end
    else if (wr_gs)
    begin
      rwu_allow_q <= wdat[GS_RWU_ALLOW];
    end
  end

  // ==========================================================
  // Remote wake-up sequencing
  assign wake_start = wr_ctrl && wdat[CR_WAKE_BIT] && !ctrl_q[CR_WAKE_BIT]
                      && bus_suspended && rwu_allow_q
                      && run_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_state_q <= WK_IDLE;
      resume_on_q <= 1'b0;
    end
    else if (ctrl_reset_q)
    begin
      wake_state_q <= WK_IDLE;
      resume_on_q <= 1'b0;
    end
    else
    begin
      case (wake_state_q)
        WK_IDLE:
        begin
          if (wake_start)
          begin
            wake_state_q <= WK_SIGNAL;
            resume_on_q <= 1'b1;
          end
        end
        WK_SIGNAL:
        begin
          if (timer_done)
          begin
            wake_state_q <= WK_WAIT_CLR;
            resume_on_q <= 1'b0;
          end
        end
        WK_WAIT_CLR:
        begin
          if (!ctrl_q[CR_WAKE_BIT])
          begin
            wake_state_q <= WK_IDLE;
          end
        end
        default:
        begin
          wake_state_q <= WK_IDLE;
          resume_on_q <= 1'b0;
        end
      endcase
    end
  end

  // Signalling duration timer
  wake_timer #(
    .CYCLES(WAKE_CNT)
  ) u_wake_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(wake_start && (wake_state_q == WK_IDLE)),
    .abort(ctrl_reset_q),
    .busy_q(),
    .done_q(timer_done)
  );

  // ==========================================================
  // Protocol event flags; hardware set wins over software write
  always_comb
  begin
    pflags_set = RST_ZERO;
    pflags_set[PF_BUS_RESET] = run_q && bus_reset_end_evt;
    pflags_set[PF_SOF] = run_q && frame_start_evt;
    pflags_set[PF_WAKE] = wr_ctrl && wdat[CR_WAKE_BIT]
                          && !ctrl_q[CR_WAKE_BIT];
    pflags_set[PF_RESUME] = run_q && resume_evt;
    pflags_set[PF_SUSPEND] = run_q && suspend_evt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pflags_q <= RST_ZERO;
    end
    else if (ctrl_reset_q)
    begin
      pflags_q <= RST_ZERO;
    end
    else if (wr_pflags)
    begin
      pflags_q <= (wdat & PF_WMASK) | pflags_set;
    end
    else
    begin
      pflags_q <= pflags_q | pflags_set;
    end
  end

  // ==========================================================
  // Mask registers and endpoint select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pmask_q <= RST_PMASK;
      epmask_q <= RST_ZERO;
      sel_q <= '0;
    end
    else
    begin
      if (wr_pmask)
      begin
        pmask_q <= wdat & PM_WMASK;
      end
      if (wr_epmask)
      begin
        epmask_q <= wdat;
      end
      if (wr_sel)
      begin
        sel_q <= wdat[SEL_W-1:0];
      end
    end
  end

  // ==========================================================
  // Per-endpoint status, CRC error and summary flags
  for (genvar e = 0; e < NUM_EP; e++)
  begin : g_ep
    logic [3:0] set_v;
    logic [3:0] clr_v;
    logic is_ctrl;
    logic is_iso;

    assign set_v = {4{run_q}} & {stall_evt[e], setup_evt[e],
                                 data_received_evt[e], txc_evt[e]};
    assign clr_v = (wr_cs && (sel_q == SEL_W'(e)))
                   ? ~wdat[3:0] & CS_STAT_MASK : 4'h0;
    assign is_ctrl = endpoint_type[2*e +: 2] == EP_CONTROL;
    assign is_iso = endpoint_type[2*e +: 2] == EP_ISO;

    // Status bits; a set in the clearing cycle is kept
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        ep_stat_q[e] <= 4'h0;
      end
      else if (ctrl_reset_q)
      begin
        ep_stat_q[e] <= 4'h0;
      end
      else
      begin
        ep_stat_q[e] <= (ep_stat_q[e] & ~clr_v) | set_v;
      end
    end

    // CRC error follows the last isochronous packet
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        iso_err_q[e] <= 1'b0;
      end
      else if (ctrl_reset_q)
      begin
        iso_err_q[e] <= 1'b0;
      end
      else if (run_q && iso_crc_bad[e])
      begin
        iso_err_q[e] <= 1'b1;
      end
      else if (run_q && iso_crc_good[e])
      begin
        iso_err_q[e] <= 1'b0;
      end
    end

    // Type-qualified interrupt condition; CRC error not included
    assign ep_cond[e] =
      (ep_stat_q[e][CS_TXC] && (is_ctrl || (!is_iso && endpoint_dir_in[e])))
      || (ep_stat_q[e][CS_DATA_RECEIVED] && (is_ctrl || !endpoint_dir_in[e]))
      || (ep_stat_q[e][CS_SETUP] && is_ctrl)
      || (ep_stat_q[e][CS_STALL] && !is_iso);

    // Summary flag tracks the sources of its endpoint
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        summary_q[e] <= 1'b0;
      end
      else
      begin
        summary_q[e] <= ep_cond[e];
      end
    end
  end

  // ==========================================================
  // Interrupt requests
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pirq_q <= 1'b0;
      eirq_q <= 1'b0;
    end
    else
    begin
      pirq_q <= pflags_q[PF_BUS_RESET]
                || |(pflags_q[3:0] & pmask_q[3:0]);
      eirq_q <= |(summary_q & epmask_q);
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign attach_pullup_on = ctrl_q[CR_PULLUP_BIT];
  assign usb_run = run_q;
  assign ctrl_reset = ctrl_reset_q;
  assign resume_k_drive = resume_on_q;
  assign endpoint_select = sel_q;
  assign protocol_irq = pirq_q;
  assign endpoint_irq = eirq_q;

endmodule

// file: hdl/wake_timer.sv
// Down-counter that times the remote wake-up resume signalling
`timescale 1ns/1ps
module wake_timer
  #(
    parameter int CYCLES = 1300000
  )
  (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic abort,
    output logic busy_q,
    output logic done_q
  );

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_q;

  // ==========================================================
  // Parameter check
  if (CYCLES < 2)
  begin : g_chk
    $error("wake_timer: CYCLES must be at least 2");
  end

  // ==========================================================
  // Counter; busy lasts exactly CYCLES clock cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (abort)
      begin
        busy_q <= 1'b0;
        cnt_q <= '0;
      end
      else if (start && !busy_q)
      begin
        busy_q <= 1'b1;
        cnt_q <= LOAD;
      end
      else if (busy_q)
      begin
        if (cnt_q == '0)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1; // One-cycle end pulse
        end
        else
        begin
          cnt_q <= cnt_q - CNT_W'(1);
        end
      end
    end
  end

endmodule

// file: tb/tb_top.sv
// Self-checking bench for the USB control and event register block
`timescale 1ns/1ps
`define CHK(g, x) \
  begin \
    num_checks++; \
    if ((g) !== (x)) \
    begin \
      n_errors++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (x)); \
    end \
  end
module tb_top import usb_ctrl_pkg::*;;
  localparam int WK = 20;
  logic pclk, presetn, psel, penable, pwrite, fire, e, q;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic pready, pslverr, power_reduce_usb, bus_suspended;
  logic bus_reset_end_evt, frame_start_evt, resume_evt, suspend_evt;
  logic [7:0] txc_evt, data_received_evt, setup_evt, stall_evt;
  logic [7:0] iso_crc_bad, iso_crc_good, endpoint_dir_in;
  logic [15:0] endpoint_type;
  logic attach_pullup_on, usb_run, ctrl_reset, resume_k_drive;
  logic protocol_irq, endpoint_irq;
  logic [2:0] endpoint_select, kind;
  int n_errors, num_checks, seed, k, ep, m;
  int mdl[8];
  int bl[4] = '{4, 3, 1, 0};
  logic [7:0] idx[8] = '{IDX_EP_SEL, IDX_EP_CS, IDX_CTRL, IDX_PFLAGS,
    IDX_PMASK, IDX_EP_SUM, IDX_EP_MASK, IDX_GSTATE};
  logic [7:0] wm[8] = '{8'h07, 8'h00, 8'ha2, 8'h1f, 8'h0f, 8'h00, 8'hff,
    8'h04};

  usb_device_ctrl_irq_regs #(.WAKE_CNT(WK)) dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .power_reduce_usb, .bus_suspended, .bus_reset_end_evt, .frame_start_evt,
    .resume_evt, .suspend_evt, .txc_evt, .data_received_evt, .setup_evt, .stall_evt,
    .iso_crc_bad, .iso_crc_good, .endpoint_type, .endpoint_dir_in,
    .attach_pullup_on, .usb_run, .ctrl_reset, .resume_k_drive,
    .endpoint_select, .protocol_irq, .endpoint_irq);
  usb_host_model host (.pclk, .presetn, .fire, .kind, .bus_reset_end_evt,
    .frame_start_evt, .resume_evt, .suspend_evt, .bus_suspended);

  // ==========================================================
  // Clock, watchdog and closing report
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    complete_run();
  end
  task automatic complete_run();
    $display("errors=%0d checks=%0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Bus and event tasks; the model mirrors every register write
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    apb(1'b1, {idx[i], 2'b00}, d);
    mdl[i] = d & wm[i];
  endtask
  task automatic rd(input int i, input logic [31:0] x);
    apb(1'b0, {idx[i], 2'b00}, 8'h00);
    `CHK(r, x)
  endtask
  task automatic ev(input int b);
    fire <= 1'b1;
    kind <= 3'(b);
    @(posedge pclk);
    fire <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic epev(input int s, input int n, input int sh);
    {stall_evt, setup_evt, data_received_evt, txc_evt} <= 32'(1 << n) << (8 * s);
    {iso_crc_good, iso_crc_bad} <= 16'(sh);
    @(posedge pclk);
    {stall_evt, setup_evt, data_received_evt, txc_evt, iso_crc_good, iso_crc_bad} <= '0;
    repeat (3) @(posedge pclk);
  endtask
  function automatic logic qual(int s, logic [1:0] t, logic din);
    case (s)
      0: return t == 2'b00 || (din && t[1]);
      1: return t == 2'b00 || !din;
      2: return t == 2'b00;
      default: return t != 2'b01;
    endcase
  endfunction

  // ==========================================================
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, fire, power_reduce_usb, presetn} = '0;
    {paddr, pwdata, kind, endpoint_type, endpoint_dir_in} = '0;
    {txc_evt, data_received_evt, setup_evt, stall_evt, iso_crc_bad, iso_crc_good} = '0;
    pstrb = 4'hf;
    seed = 45044;
    mdl = '{default: 0};
    mdl[4] = 2;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(ctrl_reset, 1'b1)
    for (int i = 0; i < 8; i++)
      rd(i, 32'(mdl[i]));
    apb(1'b0, 10'h000, 8'h00);
    `CHK(e, 1'b1)
    apb(1'b1, 10'h381, 8'hff);
    rd(2, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      wr(i, i == 2 ? 8'h5d : 8'hff);
      rd(i, i == 3 ? 32'h0 : 32'(mdl[i]));
    end
    wr(2, 8'h22);
    rd(2, 32'h22);
    wr(3, 8'hff);
    rd(3, 32'h1f);
    wr(3, 8'h00);
    `CHK(usb_run, 1'b1)
    `CHK(attach_pullup_on, 1'b1)
    for (int i = 0; i < 4; i++)
    begin
      ev(bl[i]);
      rd(3, 32'(1 << bl[i]));
      `CHK(protocol_irq, 1'b1)
      wr(3, 8'h00);
      repeat (2) @(posedge pclk);
      `CHK(protocol_irq, 1'b0)
    end
    wr(4, 8'h00);
    ev(4);
    `CHK(protocol_irq, 1'b1)
    wr(3, 8'h00);
    ev(0);
    `CHK(protocol_irq, 1'b0)
    rd(3, 32'h1);
    power_reduce_usb <= 1'b1;
    ev(3);
    `CHK(usb_run, 1'b0)
    rd(3, 32'h1);
    power_reduce_usb <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(usb_run, 1'b1)
    wr(7, 8'h00);
    wr(2, 8'ha2);
    repeat (3) @(posedge pclk);
    `CHK(resume_k_drive, 1'b0)
    rd(3, 32'h5);
    wr(3, 8'h00);
    wr(2, 8'h22);
    wr(7, 8'h04);
    wr(2, 8'ha2);
    @(posedge pclk);
    `CHK(resume_k_drive, 1'b1)
    rd(7, 32'h0c);
    k = 0;
    while (resume_k_drive === 1'b1 && k < 100)
    begin
      @(posedge pclk);
      k++;
    end
    if (k >= 100)
    begin
      n_errors++;
      complete_run();
    end
    rd(7, 32'h04);
    rd(3, 32'h4);
    wr(3, 8'h00);
    wr(2, 8'h22);
    for (int i = 0; i < 16; i++)
    begin
      ep = $random(seed) & 7;
      m = $random(seed) & 255;
      endpoint_type[2*ep +: 2] <= 2'(i / 4);
      endpoint_dir_in[ep] <= 1'($random(seed));
      wr(6, 8'(m));
      wr(0, 8'(ep));
      q = qual(i % 4, 2'(i / 4), endpoint_dir_in[ep]);
      epev(i % 4, ep, 0);
      `CHK(endpoint_select, 3'(ep))
      rd(5, 32'(q) << ep);
      `CHK(endpoint_irq, q & m[ep])
      rd(1, 32'(1 << (i % 4)));
      wr(1, 8'h00);
      rd(5, 32'h0);
      `CHK(endpoint_irq, 1'b0)
    end
    wr(6, 8'hff);
    wr(0, 8'h05);
    epev(4, 0, 16'h0020);
    rd(1, 32'h40);
    `CHK(endpoint_irq, 1'b0)
    epev(4, 0, 16'h2000);
    rd(1, 32'h00);
    ev(3);
    wr(2, 8'h20);
    repeat (2) @(posedge pclk);
    `CHK(ctrl_reset, 1'b1)
    `CHK(usb_run, 1'b0)
    rd(3, 32'h0);
    `CHK(attach_pullup_on, 1'b1)
    complete_run();
  end
endmodule

// file: tb/usb_ctrl_sva.sv
// Assertion checker for the USB control and event register block
`timescale 1ns/1ps
module usb_ctrl_sva
  import usb_ctrl_pkg::*;
  #(
    parameter int WAKE_CNT = WAKE_CYCLES
  )
  (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic power_reduce_usb,
    input wire logic bus_reset_end_evt,
    input wire logic usb_run,
    input wire logic resume_k_drive,
    input wire logic attach_pullup_on,
    input wire logic [SEL_W-1:0] endpoint_select,
    input wire logic protocol_irq
  );
  localparam logic [ADDR_W-1:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] A_SEL = {IDX_EP_SEL, 2'b00};
  logic wake_wr_q;
  int high_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Helpers: wake-up write seen, length of resume signalling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_wr_q <= 1'b0;
    else
      wake_wr_q <= psel && penable && pready && pwrite && pstrb[0]
        && paddr == A_CTRL && pwdata[CR_WAKE_BIT];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      high_q <= 0;
    else
      high_q <= resume_k_drive ? high_q + 1 : 0;
  end

  // ==========================================================
  // Properties
  sequence acc_wr(logic [ADDR_W-1:0] a);
    psel && penable && pready && pwrite && pstrb[0] && paddr == a;
  endsequence
  sequence reset_end_seen;
    bus_reset_end_evt && usb_run ##1 usb_run;
  endsequence

  ready_once_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer in the access cycle");
  misalign_err_a: assert property (
    psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
    else $error("misaligned access not refused");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("unused read data bits not zero");
  pullup_wr_a: assert property (
    acc_wr(A_CTRL) |=> attach_pullup_on == $past(pwdata[CR_PULLUP_BIT]))
    else $error("pull-up output does not follow control write");
  select_wr_a: assert property (
    acc_wr(A_SEL) |=> endpoint_select == $past(pwdata[2:0]))
    else $error("endpoint select does not follow write");
  power_freeze_a: assert property (power_reduce_usb |=> !usb_run)
    else $error("block runs while power reduced");
  reset_end_irq_a: assert property (reset_end_seen |=> protocol_irq)
    else $error("bus reset end did not raise protocol request");
  wake_start_a: assert property ($rose(resume_k_drive) |-> wake_wr_q)
    else $error("resume signalling without wake-up write");
  wake_len_a: assert property ($fell(resume_k_drive) |->
    high_q >= WAKE_CNT - 1 && high_q <= WAKE_CNT + 1)
    else $error("resume signalling length wrong");
endmodule

bind usb_device_ctrl_irq_regs usb_ctrl_sva #(.WAKE_CNT(WAKE_CNT)) chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .power_reduce_usb, .bus_reset_end_evt,
  .usb_run, .resume_k_drive, .attach_pullup_on, .endpoint_select,
  .protocol_irq);

// file: tb/usb_host_model.sv
// Behavioural host side: bus event pulses and bus suspend state
`timescale 1ns/1ps
module usb_host_model
  (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    input wire logic [2:0] kind,
    output logic bus_reset_end_evt,
    output logic frame_start_evt,
    output logic resume_evt,
    output logic suspend_evt,
    output logic bus_suspended
  );
  logic [4:0] ev_q;

  // One-cycle pulse per request, bit index equals flag position
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ev_q <= 5'h00;
    else
      ev_q <= fire ? 5'(1 << kind) : 5'h00;
  end

  // Idle bus enters suspend; resume or bus reset leaves it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_suspended <= 1'b0;
    else if (ev_q[0])
      bus_suspended <= 1'b1;
    else if (ev_q[1] || ev_q[4])
      bus_suspended <= 1'b0;
  end

  assign suspend_evt = ev_q[0];
  assign resume_evt = ev_q[1];
  assign frame_start_evt = ev_q[3];
  assign bus_reset_end_evt = ev_q[4];
endmodule
